//--- core/scl_axis.sv
// module: per-axis loop, speed, window, microstep, chopper and adaptive current logic
`timescale 1ns/1ps
// Functional notes
// - loop mode: open, closed, two PID modes
// - init flag 0 while initialising, then 1
// - averaged and instant signed encoder speeds
// - target reached when deviation within window
// - resolution code n gives 2^n microsteps
// - two-bit comparator blanking time select
// - mode bit: hysteresis or constant off-time
// - disable bit stops comparator ending fast decay
// - hysteresis start offset or sine offset
// - off time 12+32*setting, minimum 64 clocks
// - off setting zero frees all transistors
// - current floor half or quarter of run current
// - down-step code needs 32,8,2,1 high readings
module scl_axis
	import scl_pkg::*;
#(
	parameter int GATE_CYCLES = SPEED_GATE_CYC,
	parameter int INIT_CYCLES = INIT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// encoder and position
	input wire logic enc_pulse,
	input wire logic enc_dir,
	input wire logic [31:0] target_pos,
	input wire logic [31:0] actual_pos,
	// current sense and load
	input wire logic cur_cmp_trip,
	input wire logic load_valid,
	input wire logic [9:0] load_value,
	input wire logic [4:0] run_current,
	// motor side results
	output logic [1:0] loop_mode,
	output logic loop_init_done,
	output logic target_reached,
	output logic [8:0] ustep_incr,
	output scl_drv_t drv,
	output logic [4:0] cmp_offset,
	output logic [4:0] current_scale
);
	// ==========================================================
	// elaboration checks
	if (GATE_CYCLES < 2) begin : g_bad_gate
		$error("GATE_CYCLES must be at least 2");
	end
	if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
		$error("INIT_CYCLES must lie in 1..65535");
	end

	// ==========================================================
	// helpers
	function automatic logic [32:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] d;
		d = {a[31], a} - {b[31], b};
		abs_diff = d[32] ? 33'(-d) : d;
	endfunction : abs_diff

	function automatic logic [8:0] off_cycles(input logic [3:0] t);
		logic [8:0] c;
		c = OFF_BASE + 9'({t, 5'h00} >> (5 - OFF_MULT_SHIFT));
		off_cycles = (c < OFF_MIN) ? OFF_MIN : c;
	endfunction : off_cycles

	function automatic logic [8:0] blank_cycles(input logic [1:0] b);
		case (b)
			2'h0: blank_cycles = BLANK_0;
			2'h1: blank_cycles = BLANK_1;
			2'h2: blank_cycles = BLANK_2;
			default: blank_cycles = BLANK_3;
		endcase
	endfunction : blank_cycles

	function automatic logic [5:0] down_need(input logic [1:0] c);
		case (c)
			2'h0: down_need = 6'h20;
			2'h1: down_need = 6'h08;
			2'h2: down_need = 6'h02;
			default: down_need = 6'h01;
		endcase
	endfunction : down_need

	// ==========================================================
	// reset release
	logic [1:0] rst_q;
	logic rst_ok;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_ok = rst_q[1];

	// ==========================================================
	// state
	scl_state_t s;
	scl_state_t next_s;
	logic in_win;
	logic [4:0] cur_floor;
	logic [5:0] dn_need_now;
	logic load_high;
	logic [31:0] acc_now;
	logic [31:0] speed_diff;

	assign in_win = abs_diff(target_pos, actual_pos) <= {1'b0, s.window};
	assign cur_floor = s.floor_sel ? (run_current >> 2) : (run_current >> 1);
	assign dn_need_now = down_need(s.down_step);
	assign load_high = load_value > 10'({s.hyst, 6'h00} >> (6 - LOAD_THR_SHIFT));

	always_comb begin
		next_s = s;
		next_s.rdata = 32'h0;
		acc_now = s.pulse_acc;
		speed_diff = 32'h0;

		// register writes; read-only and unmapped indexes ignore writes
		if (reg_wr) begin
			case (reg_addr)
				A_LOOP_MODE_SELECT: begin
					next_s.loop_mode = reg_wdata[1:0];
					if (reg_wdata[1:0] == LOOP_OPEN) begin
						next_s.init_done = 1'b0;
						next_s.init_cnt = 16'h0;
					end else if (s.loop_mode == LOOP_OPEN) begin
						next_s.init_done = 1'b0;
						next_s.init_cnt = 16'(INIT_CYCLES);
					end
				end
				A_TARGET_WINDOW: next_s.window = {1'b0, reg_wdata[30:0]};
				A_ENCODER_FILTER_WAIT: next_s.flt_wait = reg_wdata;
				A_ENCODER_FILTER_DEPTH: next_s.flt_depth = reg_wdata;
				A_ENCODER_FILTER_INTERVAL: next_s.flt_int = reg_wdata;
				A_STEP_RESOLUTION: begin
					// codes above the finest resolution are dropped, not clipped
					if (reg_wdata[31:0] <= 32'(RES_MAX)) begin
						next_s.res = reg_wdata[3:0];
					end
				end
				A_COMPARATOR_BLANK_TIME: next_s.blank = reg_wdata[1:0];
				A_CHOPPER_MODE_SELECT: next_s.chop_mode = reg_wdata[0];
				A_FAST_DECAY_COMPARATOR_OFF: next_s.fd_cmp_off = reg_wdata[0];
				A_HYST_END_OR_FAST_DECAY: next_s.hend = reg_wdata[3:0];
				A_HYST_START_OR_SINE_OFFSET: begin
					if (reg_wdata[31:0] <= 32'(HSTART_MAX)) begin
						next_s.hstart = reg_wdata[3:0];
					end
				end
				A_CHOPPER_OFF_TIME: next_s.chopper_off_setting = reg_wdata[3:0];
				A_ADAPTIVE_CURRENT_FLOOR: next_s.floor_sel = reg_wdata[0];
				A_ADAPTIVE_CURRENT_DOWN_STEP: next_s.down_step = reg_wdata[1:0];
				A_ADAPTIVE_CURRENT_HYSTERESIS: next_s.hyst = reg_wdata[3:0];
				default: ;
			endcase
		end

		// register reads; narrow fields sit low, unmapped reads zero
		if (reg_rd) begin
			case (reg_addr)
				A_LOOP_MODE_SELECT: next_s.rdata = {30'h0, s.loop_mode};
				A_AVERAGED_ENCODER_SPEED: next_s.rdata = s.avg_speed;
				A_INSTANT_ENCODER_SPEED: next_s.rdata = s.inst_speed;
				A_LOOP_INIT_DONE: next_s.rdata = {31'h0, s.init_done};
				A_TARGET_WINDOW: next_s.rdata = s.window;
				A_ENCODER_FILTER_WAIT: next_s.rdata = s.flt_wait;
				A_ENCODER_FILTER_DEPTH: next_s.rdata = s.flt_depth;
				A_ENCODER_FILTER_INTERVAL: next_s.rdata = s.flt_int;
				A_STEP_RESOLUTION: next_s.rdata = {28'h0, s.res};
				A_COMPARATOR_BLANK_TIME: next_s.rdata = {30'h0, s.blank};
				A_CHOPPER_MODE_SELECT: next_s.rdata = {31'h0, s.chop_mode};
				A_FAST_DECAY_COMPARATOR_OFF: next_s.rdata = {31'h0, s.fd_cmp_off};
				A_HYST_END_OR_FAST_DECAY: next_s.rdata = {28'h0, s.hend};
				A_HYST_START_OR_SINE_OFFSET: next_s.rdata = {28'h0, s.hstart};
				A_CHOPPER_OFF_TIME: next_s.rdata = {28'h0, s.chopper_off_setting};
				A_ADAPTIVE_CURRENT_FLOOR: next_s.rdata = {31'h0, s.floor_sel};
				A_ADAPTIVE_CURRENT_DOWN_STEP: next_s.rdata = {30'h0, s.down_step};
				A_ADAPTIVE_CURRENT_HYSTERESIS: next_s.rdata = {28'h0, s.hyst};
				default: next_s.rdata = 32'h0;
			endcase
		end

		// closed loop start-up timer; a write of open loop in the same cycle wins
		if (s.init_cnt != 16'h0 && next_s.loop_mode != LOOP_OPEN) begin
			next_s.init_cnt = s.init_cnt - 16'h1;
			if (s.init_cnt == 16'h1) begin
				next_s.init_done = 1'b1;
			end
		end

		// encoder speed: signed pulse count over a one second gate is pulses per second
		if (enc_pulse) begin
			acc_now = enc_dir ? s.pulse_acc - 32'h1 : s.pulse_acc + 32'h1;
		end
		if (s.gate_cnt >= 32'(GATE_CYCLES - 1)) begin
			next_s.gate_cnt = 32'h0;
			next_s.pulse_acc = 32'h0;
			next_s.inst_speed = acc_now;
			// first-order average; depth picks the shift, trading lag for smoothness
			speed_diff = acc_now - s.avg_speed;
			next_s.avg_speed = s.avg_speed + 32'($signed(speed_diff) >>> s.flt_depth[2:0]);
		end else begin
			next_s.gate_cnt = s.gate_cnt + 32'h1;
			next_s.pulse_acc = acc_now;
		end

		// positioning window
		next_s.target_reached = in_win;

		// microstep index increment into a 256 entry table
		next_s.ustep_incr = USTEP_FULL >> next_s.res;

		// comparator threshold offset
		if (!s.chop_mode) begin
			next_s.cmp_offset = 5'(s.hend) + 5'(s.hstart);
		end else begin
			next_s.cmp_offset = 5'(s.hstart);
		end

		// chopper phase sequencer
		case (s.chop)
			CH_FREE: begin
				if (s.chopper_off_setting != 4'h0) begin
					next_s.chop = CH_ON;
					next_s.cnt = blank_cycles(s.blank);
				end
			end
			CH_ON: begin
				if (s.cnt != 9'h0) begin
					next_s.cnt = s.cnt - 9'h1;
				end else if (cur_cmp_trip) begin
					if (s.chop_mode && s.hend != 4'h0) begin
						next_s.chop = CH_FAST;
						next_s.cnt = 9'({s.hend, 5'h00} >> (5 - FD_MULT_SHIFT)) - 9'h1;
					end else begin
						next_s.chop = CH_SLOW;
						next_s.cnt = off_cycles(s.chopper_off_setting) - 9'h1;
					end
				end
			end
			CH_FAST: begin
				if ((cur_cmp_trip && !s.fd_cmp_off) || s.cnt == 9'h0) begin
					next_s.chop = CH_SLOW;
					next_s.cnt = off_cycles(s.chopper_off_setting) - 9'h1;
				end else begin
					next_s.cnt = s.cnt - 9'h1;
				end
			end
			CH_SLOW: begin
				if (s.cnt == 9'h0) begin
					next_s.chop = CH_ON;
					next_s.cnt = blank_cycles(s.blank);
				end else begin
					next_s.cnt = s.cnt - 9'h1;
				end
			end
			default: begin
				next_s.chop = CH_FREE;
				next_s.cnt = 9'h0;
			end
		endcase
		// a zero off setting overrides every phase
		if (s.chopper_off_setting == 4'h0) begin
			next_s.chop = CH_FREE;
			next_s.cnt = 9'h0;
		end
		next_s.drv.all_off = next_s.chop == CH_FREE;
		next_s.drv.bridge_on = next_s.chop == CH_ON;
		next_s.drv.fast_decay = next_s.chop == CH_FAST;
		next_s.drv.slow_decay = next_s.chop == CH_SLOW;

		// load adaptive current reduction
		if (load_valid) begin
			if (load_high) begin
				if (s.dn_cnt + 6'h1 >= dn_need_now) begin
					next_s.dn_cnt = 6'h0;
					if (s.cur_scale > cur_floor) begin
						next_s.cur_scale = s.cur_scale - 5'h1;
					end
				end else begin
					next_s.dn_cnt = s.dn_cnt + 6'h1;
				end
			end else begin
				next_s.dn_cnt = 6'h0;
			end
		end
		// keep the scale inside floor..run even when run current moves
		if (next_s.cur_scale > run_current) begin
			next_s.cur_scale = run_current;
		end
		if (next_s.cur_scale < cur_floor) begin
			next_s.cur_scale = cur_floor;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_q[1]) begin
		if (!rst_q[1]) begin
			s <= '0;
			s.res <= RES_RST;
			s.ustep_incr <= USTEP_FULL >> RES_RST;
			s.blank <= BLANK_RST;
			s.chopper_off_setting <= CHOPPER_OFF_SETTING_RST;
			s.hend <= HEND_RST;
			s.hstart <= HSTART_RST;
			s.down_step <= DOWN_RST;
			s.hyst <= HYST_RST;
			s.chop <= CH_FREE;
			s.drv <= '{all_off: 1'b1, default: 1'b0};
			s.cur_scale <= CUR_MAX;
			s.loop_mode <= LOOP_OPEN;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = s.rdata;
	assign loop_mode = s.loop_mode;
	assign loop_init_done = s.init_done;
	assign target_reached = s.target_reached;
	assign ustep_incr = s.ustep_incr;
	assign drv = s.drv;
	assign cmp_offset = s.cmp_offset;
	assign current_scale = s.cur_scale;

	// ==========================================================
	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_ok);

	logic [8:0] slow_run;
	logic [3:0] slow_chopper_off_setting;
	always_ff @(posedge ref_clk or negedge rst_q[1]) begin
		if (!rst_q[1]) begin
			slow_run <= 9'h0;
			slow_chopper_off_setting <= 4'h0;
		end else begin
			slow_run <= s.drv.slow_decay ? slow_run + 9'h1 : 9'h0;
			if (!s.drv.slow_decay) begin
				slow_chopper_off_setting <= s.chopper_off_setting;
			end
		end
	end

	a_loop_open_flag: assert property (s.loop_mode == LOOP_OPEN |-> !s.init_done)
		else $error("init flag set in open loop");
	a_init_flag_wait: assert property (s.init_cnt != 16'h0 |-> !s.init_done)
		else $error("init flag set during initialisation");
	a_target_window: assert property ($past(rst_ok) |-> s.target_reached == $past(in_win))
		else $error("target flag does not follow window");
	a_ustep_size: assert property (s.res <= RES_MAX && $onehot(s.ustep_incr)
		&& s.ustep_incr == 9'(9'h001 << (RES_MAX - s.res)))
		else $error("microstep size wrong");
	a_blank_hold: assert property (s.drv.bridge_on && s.cnt != 9'h0 && s.chopper_off_setting != 4'h0
		|=> s.drv.bridge_on)
		else $error("on phase left during blanking");
	a_fast_in_mode: assert property ($rose(s.drv.fast_decay) |-> $past(s.chop_mode))
		else $error("fast decay in hysteresis mode");
	a_fd_cmp_off: assert property (s.drv.fast_decay && s.fd_cmp_off && s.cnt != 9'h0
		&& s.chopper_off_setting != 4'h0 |=> s.drv.fast_decay)
		else $error("comparator ended fast decay while disabled");
	a_off_time_len: assert property ($fell(s.drv.slow_decay) && s.chopper_off_setting != 4'h0
		&& $past(s.chopper_off_setting) == slow_chopper_off_setting |-> $past(slow_run) + 9'h1 == off_cycles(slow_chopper_off_setting))
		else $error("off time length wrong");
	a_free_wheel: assert property (s.chopper_off_setting == 4'h0 |=> s.drv.all_off)
		else $error("drivers active with zero off setting");
	a_current_floor: assert property (s.cur_scale >= $past(cur_floor))
		else $error("current below floor");
	a_down_step: assert property (s.cur_scale < $past(s.cur_scale)
		&& $past(s.cur_scale) <= $past(run_current)
		|-> $past(load_valid) && $past(load_high)
		&& $past(s.dn_cnt) + 6'h1 >= $past(dn_need_now))
		else $error("current decremented without enough readings");

	c_fast_decay: cover property ($rose(s.drv.fast_decay));
	c_init_done: cover property ($rose(s.init_done));
	c_target: cover property ($rose(s.target_reached));
	c_decrement: cover property (s.cur_scale < $past(s.cur_scale));
endmodule : scl_axis

//--- core/scl_pkg.sv
// package: register map, reset values, timing figures and types of the axis config block
package scl_pkg;
	// ==========================================================
	// register indexes (plain port, one register per index)
	localparam logic [7:0] A_LOOP_MODE_SELECT = 8'h81;
	localparam logic [7:0] A_AVERAGED_ENCODER_SPEED = 8'h83;
	localparam logic [7:0] A_INSTANT_ENCODER_SPEED = 8'h84;
	localparam logic [7:0] A_LOOP_INIT_DONE = 8'h85;
	localparam logic [7:0] A_TARGET_WINDOW = 8'h86;
	localparam logic [7:0] A_ENCODER_FILTER_WAIT = 8'h88;
	localparam logic [7:0] A_ENCODER_FILTER_DEPTH = 8'h89;
	localparam logic [7:0] A_ENCODER_FILTER_INTERVAL = 8'h8a;
	localparam logic [7:0] A_STEP_RESOLUTION = 8'h8c;
	localparam logic [7:0] A_COMPARATOR_BLANK_TIME = 8'ha2;
	localparam logic [7:0] A_CHOPPER_MODE_SELECT = 8'ha3;
	localparam logic [7:0] A_FAST_DECAY_COMPARATOR_OFF = 8'ha4;
	localparam logic [7:0] A_HYST_END_OR_FAST_DECAY = 8'ha5;
	localparam logic [7:0] A_HYST_START_OR_SINE_OFFSET = 8'ha6;
	localparam logic [7:0] A_CHOPPER_OFF_TIME = 8'ha7;
	localparam logic [7:0] A_ADAPTIVE_CURRENT_FLOOR = 8'ha8;
	localparam logic [7:0] A_ADAPTIVE_CURRENT_DOWN_STEP = 8'ha9;
	localparam logic [7:0] A_ADAPTIVE_CURRENT_HYSTERESIS = 8'haa;
	// ==========================================================
	// field codes and reset values
	localparam logic [1:0] LOOP_OPEN = 2'h0;
	localparam logic [1:0] LOOP_CLOSED = 2'h1;
	localparam logic [1:0] LOOP_PID_VACT = 2'h2;
	localparam logic [1:0] LOOP_PID_VZERO = 2'h3;
	localparam logic [3:0] RES_MAX = 4'h8;
	localparam logic [3:0] RES_RST = 4'h8;
	localparam logic [8:0] USTEP_FULL = 9'h100;
	localparam logic [1:0] BLANK_RST = 2'h2;
	localparam logic [3:0] CHOPPER_OFF_SETTING_RST = 4'h3;
	localparam logic [3:0] HEND_RST = 4'h0;
	localparam logic [3:0] HSTART_RST = 4'h4;
	localparam logic [3:0] HSTART_MAX = 4'h8;
	localparam logic [1:0] DOWN_RST = 2'h0;
	localparam logic [3:0] HYST_RST = 4'h0;
	localparam logic [4:0] CUR_MAX = 5'h1f;
	localparam int LOAD_THR_SHIFT = 6;
	// ==========================================================
	// timing in driver clocks
	localparam logic [8:0] OFF_BASE = 9'h00c;
	localparam int OFF_MULT_SHIFT = 5;
	localparam logic [8:0] OFF_MIN = 9'h040;
	localparam int FD_MULT_SHIFT = 5;
	localparam logic [8:0] BLANK_0 = 9'h010;
	localparam logic [8:0] BLANK_1 = 9'h018;
	localparam logic [8:0] BLANK_2 = 9'h020;
	localparam logic [8:0] BLANK_3 = 9'h028;
	localparam int CLK_HZ = 20_000_000;
	localparam int SPEED_GATE_MS = 1000;
	localparam int SPEED_GATE_CYC = (CLK_HZ / 1000) * SPEED_GATE_MS;
	localparam int INIT_CYC = 1000;
	// ==========================================================
	// types
	typedef enum logic [3:0] {
		CH_FREE = 4'b0001,
		CH_ON = 4'b0010,
		CH_FAST = 4'b0100,
		CH_SLOW = 4'b1000
	} scl_chop_st_t;

	typedef struct packed {
		logic all_off;
		logic bridge_on;
		logic fast_decay;
		logic slow_decay;
	} scl_drv_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic [1:0] loop_mode;
		logic init_done;
		logic [15:0] init_cnt;
		logic [31:0] avg_speed;
		logic [31:0] inst_speed;
		logic [31:0] pulse_acc;
		logic [31:0] gate_cnt;
		logic [31:0] window;
		logic target_reached;
		logic [31:0] flt_wait;
		logic [31:0] flt_depth;
		logic [31:0] flt_int;
		logic [3:0] res;
		logic [8:0] ustep_incr;
		logic [1:0] blank;
		logic chop_mode;
		logic fd_cmp_off;
		logic [3:0] hend;
		logic [3:0] hstart;
		logic [3:0] chopper_off_setting;
		logic [4:0] cmp_offset;
		scl_chop_st_t chop;
		logic [8:0] cnt;
		scl_drv_t drv;
		logic floor_sel;
		logic [1:0] down_step;
		logic [3:0] hyst;
		logic [5:0] dn_cnt;
		logic [4:0] cur_scale;
	} scl_state_t;
endpackage : scl_pkg

//--- tb/scl_motor_model.sv
// partner model: coil current comparator and incremental encoder of one axis
`timescale 1ns/1ps
module scl_motor_model
	import scl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// bridge state from the axis
	input wire scl_drv_t drv,
	// test controls
	input wire logic [7:0] trip_after,
	input wire logic fd_trip,
	input wire logic enc_go,
	input wire logic enc_neg,
	// sensed signals back to the axis
	output logic cur_cmp_trip,
	output logic enc_pulse,
	output logic enc_dir,
	output logic [31:0] actual_pos
);
	logic [7:0] on_cnt;
	// ==========================================================
	// coil current: trip_after sets how fast the current reaches the limit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_cnt <= 8'h00;
			enc_pulse <= 1'b0;
			enc_dir <= 1'b0;
			actual_pos <= 32'h0000_0000;
		end else begin
			on_cnt <= (drv.bridge_on && on_cnt != 8'hff) ? on_cnt + 8'h01 : 8'h00;
			// one count every other cycle, so any gate of even length sees half its cycles
			enc_pulse <= enc_go & ~enc_pulse;
			enc_dir <= enc_neg;
			if (enc_pulse) begin
				actual_pos <= enc_dir ? actual_pos - 32'h1 : actual_pos + 32'h1;
			end
		end
	end
	assign cur_cmp_trip = (drv.bridge_on && on_cnt >= trip_after) || (drv.fast_decay && fd_trip);
endmodule : scl_motor_model

//--- tb/test_stepper_chopper_loop_config.sv
// testbench: register port, loop init, speed, window, chopper and adaptive current
`timescale 1ns/1ps
module test_stepper_chopper_loop_config
	import scl_pkg::*;
;
	localparam int GATE = 100;
	localparam int INIT = 5;
	localparam logic [7:0] RA [14] = '{8'h81, 8'h85, 8'h86, 8'h88, 8'h89, 8'h8a, 8'h8c,
		8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9};
	localparam logic [31:0] RV [14] = '{0, 0, 0, 0, 0, 0, 8, 2, 0, 0, 0, 4, 3, 0};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic enc_pulse, enc_dir, cur_cmp_trip;
	logic [31:0] target_pos = 32'h0;
	logic [31:0] actual_pos;
	logic load_valid = 1'b0;
	logic [9:0] load_value = 10'h000;
	logic [4:0] run_current = 5'h14;
	logic [1:0] loop_mode;
	logic loop_init_done, target_reached;
	logic [8:0] ustep_incr;
	scl_drv_t drv;
	logic [4:0] cmp_offset, current_scale;
	logic [7:0] trip_after = 8'h00;
	logic fd_trip = 1'b0;
	logic enc_go = 1'b0;
	logic enc_neg = 1'b0;
	int checks = 0;
	int mismatches = 0;

	always #25 ref_clk = ~ref_clk;

	scl_axis #(.GATE_CYCLES(GATE), .INIT_CYCLES(INIT)) i_scl_axis (.ref_clk(ref_clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_pulse(enc_pulse), .enc_dir(enc_dir),
		.target_pos(target_pos), .actual_pos(actual_pos), .cur_cmp_trip(cur_cmp_trip),
		.load_valid(load_valid), .load_value(load_value), .run_current(run_current),
		.loop_mode(loop_mode), .loop_init_done(loop_init_done),
		.target_reached(target_reached), .ustep_incr(ustep_incr), .drv(drv),
		.cmp_offset(cmp_offset), .current_scale(current_scale));

	scl_motor_model i_scl_motor_model (.ref_clk(ref_clk), .rst_n(rst_n), .drv(drv),
		.trip_after(trip_after), .fd_trip(fd_trip), .enc_go(enc_go), .enc_neg(enc_neg),
		.cur_cmp_trip(cur_cmp_trip), .enc_pulse(enc_pulse), .enc_dir(enc_dir),
		.actual_pos(actual_pos));

	// ==========================================================
	// bus cycles and comparisons
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task chk_len(input int got, input int lo, input int hi, input string what);
		checks++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("MISMATCH at %0t: %s lasted %0d not %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_len
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp, what);
	endtask : rd_chk
	// length of the next whole high run of one bridge phase bit
	task run_len(input int b, output int len);
		int n;
		n = 0;
		len = 0;
		while (drv[b] === 1'b1 && n < 3000) begin cyc(1); n++; end
		while (drv[b] !== 1'b1 && n < 6000) begin cyc(1); n++; end
		while (drv[b] === 1'b1 && len < 3000) begin cyc(1); len++; end
	endtask : run_len
	task set_target(input int off);
		@(posedge ref_clk);
		target_pos <= actual_pos + off;
		cyc(4);
	endtask : set_target
	task load_pulse;
		@(posedge ref_clk);
		load_valid <= 1'b1;
		load_value <= 10'h064;
		@(posedge ref_clk);
		load_valid <= 1'b0;
		cyc(1);
	endtask : load_pulse

	// ==========================================================
	// scenarios
	task t_reset_values;
		logic [31:0] d;
		for (int i = 0; i < 14; i++) begin
			rd(RA[i], d);
			chk(d, RV[i], "reset value");
		end
		chk(ustep_incr, 9'h001, "ustep at reset");
		rd_chk(8'h82, 32'h0, "unmapped read");
		wr(A_LOOP_INIT_DONE, 32'h1);
		rd_chk(A_LOOP_INIT_DONE, 32'h0, "ro flag write");
		wr(A_STEP_RESOLUTION, 32'h9);
		rd_chk(A_STEP_RESOLUTION, 32'h8, "resolution 9 refused");
		wr(A_HYST_START_OR_SINE_OFFSET, 32'h9);
		rd_chk(A_HYST_START_OR_SINE_OFFSET, 32'h4, "hstart 9 refused");
	endtask : t_reset_values
	task t_loop_speed_window;
		int n;
		// resolution stays 8 while the loop is closed
		wr(A_LOOP_MODE_SELECT, LOOP_CLOSED);
		chk(loop_init_done, 1'b0, "init flag early");
		n = 0;
		while (loop_init_done !== 1'b1 && n < 100) begin cyc(1); n++; end
		chk_len(n, INIT, INIT + 1, "loop init");
		rd_chk(A_LOOP_INIT_DONE, 32'h1, "init flag read");
		// motion only after the flag reads 1
		@(posedge ref_clk);
		enc_neg <= 1'b1;
		enc_go <= 1'b1;
		cyc(250);
		rd_chk(A_INSTANT_ENCODER_SPEED, -32'sd50, "instant speed");
		rd_chk(A_AVERAGED_ENCODER_SPEED, -32'sd50, "averaged speed");
		enc_go <= 1'b0;
		cyc(3);
		wr(A_TARGET_WINDOW, 32'h3);
		set_target(3);
		chk(target_reached, 1'b1, "window edge");
		set_target(4);
		chk(target_reached, 1'b0, "window exceeded");
		set_target(-3);
		chk(target_reached, 1'b1, "window negative");
		wr(A_TARGET_WINDOW, 32'hffff_ffff);
		rd_chk(A_TARGET_WINDOW, 32'h7fff_ffff, "window max");
		for (int m = 2; m < 5; m++) begin
			wr(A_LOOP_MODE_SELECT, m[1:0]);
			cyc(1);
			chk(loop_mode, m[1:0], "loop mode");
			chk(loop_init_done, m < 4, "flag by mode");
		end
	endtask : t_loop_speed_window
	task t_resolution;
		for (int r = 0; r < 9; r++) begin
			wr(A_STEP_RESOLUTION, r);
			cyc(2);
			chk(ustep_incr, 9'h100 >> r, "microstep");
		end
	endtask : t_resolution
	task t_chopper;
		int len;
		int exp_off [3] = '{64, 140, 300};
		logic [3:0] toffs [3] = '{4'h1, 4'h4, 4'h9};
		wr(A_CHOPPER_OFF_TIME, 32'h1);
		for (int c = 0; c < 4; c++) begin
			wr(A_COMPARATOR_BLANK_TIME, c);
			run_len(2, len);
			chk_len(len, 17 + 8 * c, 18 + 8 * c, "blanking");
		end
		wr(A_COMPARATOR_BLANK_TIME, 32'h0);
		trip_after <= 8'h3c;
		run_len(2, len);
		chk_len(len, 60, 63, "slow current rise");
		trip_after <= 8'h00;
		// 9 gives 300 clocks, 15 us at this clock
		for (int i = 0; i < 3; i++) begin
			wr(A_CHOPPER_OFF_TIME, toffs[i]);
			run_len(0, len);
			chk_len(len, exp_off[i], exp_off[i], "off time");
		end
		wr(A_HYST_END_OR_FAST_DECAY, 32'h2);
		cyc(2);
		chk(cmp_offset, 5'h06, "hysteresis sum");
		wr(A_CHOPPER_MODE_SELECT, 32'h1);
		wr(A_FAST_DECAY_COMPARATOR_OFF, 32'h1);
		fd_trip <= 1'b1;
		run_len(1, len);
		chk_len(len, 64, 64, "fast decay time");
		chk(cmp_offset, 5'h04, "sine offset");
		wr(A_FAST_DECAY_COMPARATOR_OFF, 32'h0);
		run_len(1, len);
		chk_len(len, 1, 3, "fast decay cut");
		wr(A_CHOPPER_OFF_TIME, 32'h0);
		cyc(3);
		chk(drv, 4'b1000, "free wheel");
		fd_trip <= 1'b0;
	endtask : t_chopper
	task t_adaptive;
		int need [4] = '{32, 8, 2, 1};
		logic [4:0] s;
		wr(A_ADAPTIVE_CURRENT_HYSTERESIS, 32'h1);
		for (int c = 0; c < 4; c++) begin
			wr(A_ADAPTIVE_CURRENT_DOWN_STEP, c);
			s = current_scale;
			repeat (need[c] - 1) load_pulse();
			chk(current_scale, s, "no early step");
			load_pulse();
			chk(current_scale, s - 5'h01, "down step");
		end
		repeat (8) load_pulse();
		chk(current_scale, 5'h0a, "half floor");
		wr(A_ADAPTIVE_CURRENT_FLOOR, 32'h1);
		repeat (8) load_pulse();
		chk(current_scale, 5'h05, "quarter floor");
	endtask : t_adaptive

	// ==========================================================
	// verdict
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(3);
		t_reset_values();
		t_loop_speed_window();
		t_resolution();
		t_chopper();
		t_adaptive();
		tally_and_finish();
	end
	// the whole run needs under 10000 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		mismatches++;
		$display("MISMATCH at %0t: run did not finish", $time);
		tally_and_finish();
	end
endmodule : test_stepper_chopper_loop_config
